// *** rtl/gated_frequency_counter.sv ***
// Purpose: frequency measurement mode of an 18-bit up-counter with window gate
// Assumes: aclk is the high-frequency clock; low_freq_tick is a one-cycle strobe
// Notes:   registers reached over AXI4-Lite; inputs are synchronous to aclk
`timescale 1ns/1ps

module gated_frequency_counter
   import freq_meas_pkg::*;
#(
   parameter int count_width = 18
)
(
   // clock and reset
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   // axi4-lite write address
   input  wire logic                     s_axi_awvalid,
   output      logic                     s_axi_awready,
   input  wire logic [7:0]               s_axi_awaddr,
   input  wire logic [2:0]               s_axi_awprot,
   // axi4-lite write data
   input  wire logic                     s_axi_wvalid,
   output      logic                     s_axi_wready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   // axi4-lite write response
   output      logic                     s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   output      logic [1:0]               s_axi_bresp,
   // axi4-lite read address
   input  wire logic                     s_axi_arvalid,
   output      logic                     s_axi_arready,
   input  wire logic [7:0]               s_axi_araddr,
   input  wire logic [2:0]               s_axi_arprot,
   // axi4-lite read data
   output      logic                     s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   output      logic [31:0]              s_axi_rdata,
   output      logic [1:0]               s_axi_rresp,
   // measured signal and gate sources
   input  wire logic                     pulse_input_pin,
   input  wire logic                     pulse_input_signal,
   input  wire logic                     companion_timer_output,
   input  wire logic                     low_freq_tick,
   // pin routing and event
   output      logic                     gate_output_port_pin,
   output      logic                     gate_output_port_pin_oe,
   output      logic                     measure_interrupt
);
   import freq_meas_pkg::*;

   // refused at elaboration: the capture word is only 32 bits wide
   if (count_width < 1 || count_width > 32)
   begin
      $error("count_width must be 1 to 32");
   end

   logic [7:0]             timer_control_first_q;
   logic [7:0]             timer_control_second_q;
   logic [7:0]             gate_period_setting_q;
   logic [count_width-1:0] count_q;
   logic                   count_overflow_flag_q;
   logic [div_width-1:0]   div_q;
   gen_state_e             gen_q;
   logic [4:0]             span_q;
   logic                   gate_q;
   logic                   pulse_q;
   logic                   and_q;
   logic                   irq_q;
   logic                   pin_q;
   logic                   pin_oe_q;
   logic                   bvalid_q;
   logic [1:0]             bresp_q;
   logic                   rvalid_q;
   logic [31:0]            rdata_q;
   logic [1:0]             rresp_q;

   logic [1:0]             run_control_field;
   logic [2:0]             source_clock_select;
   logic [1:0]             gate_source_select;
   logic                   gate_irq_edge_select;
   logic                   gate_combine_select;
   logic [1:0]             gate_prescale_select;
   logic                   divider_stage_select;
   logic                   gate_output_route_bit;
   logic [3:0]             gate_high_setting;
   logic [3:0]             gate_low_setting;
   logic                   running;
   logic                   wr_go;
   logic                   rd_go;
   logic                   counter_clear_bit;
   logic                   presc_tick;
   logic                   gate_now;
   logic                   int_gate;
   logic                   gate_active_flag;
   logic                   count_inc;
   logic [31:0]            count_word;

   assign run_control_field     = timer_control_first_q[run_lsb +: 2];
   assign source_clock_select   = timer_control_first_q[src_lsb +: 3];
   assign gate_source_select    = timer_control_second_q[gsrc_lsb +: 2];
   assign gate_irq_edge_select  = timer_control_second_q[edge_pos];
   assign gate_combine_select   = timer_control_second_q[combine_pos];
   assign gate_prescale_select  = timer_control_second_q[prescale_lsb +: 2];
   assign divider_stage_select  = timer_control_second_q[divstage_pos];
   assign gate_output_route_bit = timer_control_second_q[route_pos];
   assign gate_high_setting     = gate_period_setting_q[high_lsb +: 4];
   assign gate_low_setting      = gate_period_setting_q[low_lsb +: 4];

   // counting needs both start and the external source selected
   assign running = (run_control_field == run_start) && (source_clock_select == src_external);

   // bus handshake: address and data are taken together
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign rd_go         = s_axi_arvalid && !rvalid_q;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // clear is a write-one strobe, never stored
   assign counter_clear_bit = wr_go && (s_axi_awaddr == ctrl_first_off) && s_axi_wstrb[0]
                              && s_axi_wdata[clear_pos];

   // control registers; only byte lane 0 carries bits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         timer_control_first_q  <= ctrl_first_rst;
         timer_control_second_q <= ctrl_second_rst;
         gate_period_setting_q  <= gate_period_rst;
      end
      else if (wr_go && s_axi_wstrb[0])
      begin
         if (s_axi_awaddr == ctrl_first_off)
         begin
            timer_control_first_q <= s_axi_wdata[7:0] & ~(8'h01 << clear_pos);
         end
         else if (s_axi_awaddr == ctrl_second_off)
         begin
            timer_control_second_q <= s_axi_wdata[7:0];
         end
         else if (s_axi_awaddr == gate_period_off)
         begin
            gate_period_setting_q <= s_axi_wdata[7:0];
         end
      end
   end

   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= resp_okay;
      end
      else if (wr_go)
      begin
         bvalid_q <= 1'b1;
         if (s_axi_awaddr == ctrl_first_off || s_axi_awaddr == ctrl_second_off
             || s_axi_awaddr == gate_period_off || s_axi_awaddr == capture_off
             || s_axi_awaddr == status_off)
         begin
            bresp_q <= resp_okay;
         end
         else
         begin
            bresp_q <= resp_decerr;
         end
      end
      else if (s_axi_bready)
      begin
         bvalid_q <= 1'b0;
      end
   end

   assign count_word = 32'(count_q);

   // read path; capture and status are read-only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= resp_okay;
      end
      else if (rd_go)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= resp_okay;
         if (s_axi_araddr == ctrl_first_off)
         begin
            rdata_q <= {24'h0, timer_control_first_q};
         end
         else if (s_axi_araddr == ctrl_second_off)
         begin
            rdata_q <= {24'h0, timer_control_second_q};
         end
         else if (s_axi_araddr == capture_off)
         begin
            rdata_q <= count_word;
         end
         else if (s_axi_araddr == gate_period_off)
         begin
            rdata_q <= {24'h0, gate_period_setting_q};
         end
         else if (s_axi_araddr == status_off)
         begin
            rdata_q <= 32'((32'(gate_active_flag) << active_pos)
                           | (32'(count_overflow_flag_q) << ovf_pos));
         end
         else
         begin
            rdata_q <= 32'h0;
            rresp_q <= resp_decerr;
         end
      end
      else if (s_axi_rready)
      begin
         rvalid_q <= 1'b0;
      end
   end

   // internal divider runs freely so the gate lines up with it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_q <= '0;
      end
      else if (!divider_stage_select || low_freq_tick)
      begin
         div_q <= div_q + 1'b1;
      end
   end

   // prescale tick: low exponent bits all ones as the divider advances
   always_comb
   begin
      int                   expo;
      logic [div_width-1:0] mask;
      expo = 0;
      mask = '0;
      if (divider_stage_select)
      begin
         expo = fs_exp_base + int'(gate_prescale_select);
      end
      else
      begin
         expo = fc_exp_base + int'(gate_prescale_select);
      end
      mask = div_width'((64'h1 << expo) - 64'h1);
      presc_tick = (gate_prescale_select != prescale_none)
                   && (!divider_stage_select || low_freq_tick)
                   && ((div_q & mask) == mask);
   end

   // internal gate generator; waits for a tick before the first window
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gen_q  <= gen_idle;
         span_q <= 5'h0;
      end
      else if (!running || gate_source_select != gsrc_internal)
      begin
         gen_q  <= gen_idle;
         span_q <= 5'h0;
      end
      else if (presc_tick)
      begin
         case (gen_q)
            gen_idle:
            begin
               gen_q  <= gen_high;
               span_q <= gate_span - {1'b0, gate_high_setting};
            end
            gen_high:
            begin
               if (span_q <= 5'h1)
               begin
                  gen_q  <= gen_low;
                  // low length latched on entry, so later writes wait
                  span_q <= gate_span - {1'b0, gate_low_setting};
               end
               else
               begin
                  span_q <= span_q - 5'h1;
               end
            end
            gen_low:
            begin
               if (span_q <= 5'h1)
               begin
                  gen_q  <= gen_high;
                  span_q <= gate_span - {1'b0, gate_high_setting};
               end
               else
               begin
                  span_q <= span_q - 5'h1;
               end
            end
            default:
            begin
               gen_q  <= gen_idle;
               span_q <= 5'h0;
            end
         endcase
      end
   end

   assign int_gate = (gen_q == gen_high);

   // window gate selection
   always_comb
   begin
      if (!running)
      begin
         gate_now = 1'b0;
      end
      else if (gate_source_select == gsrc_pin)
      begin
         gate_now = pulse_input_signal;
      end
      else if (gate_source_select == gsrc_internal)
      begin
         gate_now = int_gate;
      end
      else if (gate_source_select == gsrc_companion)
      begin
         gate_now = companion_timer_output;
      end
      else
      begin
         gate_now = 1'b0;
      end
   end

   assign gate_active_flag = gate_now;

   // edge history
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gate_q  <= 1'b0;
         pulse_q <= 1'b0;
         and_q   <= 1'b0;
      end
      else
      begin
         gate_q  <= gate_now;
         pulse_q <= pulse_input_pin;
         and_q   <= pulse_input_pin && gate_now;
      end
   end

   always_comb
   begin
      if (!running)
      begin
         count_inc = 1'b0;
      end
      else if (gate_combine_select)
      begin
         // input falls inside the window, plus one at every gate fall
         count_inc = (pulse_q && !pulse_input_pin && gate_q && gate_now)
                     || (gate_q && !gate_now);
      end
      else
      begin
         count_inc = and_q && !(pulse_input_pin && gate_now);
      end
   end

   // counter keeps its value between windows unless cleared
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_q <= '0;
      end
      else if (counter_clear_bit)
      begin
         count_q <= '0;
      end
      else if (count_inc)
      begin
         count_q <= count_q + 1'b1;
      end
   end

   // a wrap in the clearing cycle still sets the flag
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_overflow_flag_q <= 1'b0;
      end
      else if (count_inc && (&count_q))
      begin
         count_overflow_flag_q <= 1'b1;
      end
      else if (counter_clear_bit)
      begin
         count_overflow_flag_q <= 1'b0;
      end
   end

   // measurement event pulse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= (gate_q && !gate_now) || (gate_irq_edge_select && !gate_q && gate_now);
      end
   end

   assign measure_interrupt = irq_q;

   // pin routing only; companion timer run state is not touched here
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_q    <= 1'b0;
         pin_oe_q <= 1'b0;
      end
      else
      begin
         pin_q    <= companion_timer_output && !gate_output_route_bit;
         pin_oe_q <= !gate_output_route_bit;
      end
   end

   assign gate_output_port_pin    = pin_q;
   assign gate_output_port_pin_oe = pin_oe_q;

endmodule

// *** common/freq_meas_pkg.sv ***
// Purpose: constants shared by the gated frequency counter
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   offsets are byte addresses
package freq_meas_pkg;

   // register map
   localparam logic [7:0] ctrl_first_off   = 8'h00;
   localparam logic [7:0] ctrl_second_off  = 8'h04;
   localparam logic [7:0] capture_off      = 8'h08;
   localparam logic [7:0] gate_period_off  = 8'h0c;
   localparam logic [7:0] status_off       = 8'h10;

   // timer_control_first fields
   localparam int run_lsb        = 0;
   localparam int src_lsb        = 2;
   localparam int clear_pos      = 5;
   // timer_control_second fields
   localparam int gsrc_lsb       = 0;
   localparam int edge_pos       = 2;
   localparam int combine_pos    = 3;
   localparam int prescale_lsb   = 4;
   localparam int divstage_pos   = 6;
   localparam int route_pos      = 7;
   // gate_period_setting fields
   localparam int high_lsb       = 0;
   localparam int low_lsb        = 4;
   // measure_status_register fields
   localparam int active_pos     = 7;
   localparam int ovf_pos        = 6;

   // reset values
   localparam logic [7:0] ctrl_first_rst   = 8'h00;
   localparam logic [7:0] ctrl_second_rst  = 8'h00;
   localparam logic [7:0] gate_period_rst  = 8'h00;

   // encodings
   localparam logic [1:0] run_stop         = 2'h0;
   localparam logic [1:0] run_start        = 2'h2;
   localparam logic [2:0] src_external     = 3'h7;
   localparam logic [1:0] gsrc_pin         = 2'h0;
   localparam logic [1:0] gsrc_internal    = 2'h1;
   localparam logic [1:0] gsrc_companion   = 2'h2;
   localparam logic [1:0] prescale_none    = 2'h3;

   // gate prescale exponents, high- and low-frequency divider chains
   localparam int fc_exp_base    = 12;
   localparam int fs_exp_base    = 4;
   localparam int div_width      = 14;
   localparam logic [4:0] gate_span = 5'h10;

   typedef enum logic [1:0]
   {
      gen_idle = 2'b00,
      gen_high = 2'b01,
      gen_low  = 2'b10
   } gen_state_e;

   localparam logic [1:0] resp_okay   = 2'h0;
   localparam logic [1:0] resp_decerr = 2'h3;

endpackage

// *** dv/freq_meas_checker_assertions.sv ***
// Purpose: bus and pin timing checks for the gated frequency counter
// Assumes: bound to the top module, ports joined by name
// Notes:   counter state is internal, so counts are judged by the bench
`timescale 1ns/1ps
module freq_meas_checker
   import freq_meas_pkg::*;
#(
   parameter int count_width = 18
)
(
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   // pins
   input wire logic        companion_timer_output,
   input wire logic        gate_output_port_pin,
   input wire logic        gate_output_port_pin_oe,
   input wire logic        measure_interrupt
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
      else $error("write not answered one cycle after it was taken");
   a_accept_pair: assert property (s_axi_awready |-> s_axi_wready && s_axi_wvalid && !s_axi_bvalid)
      else $error("write address taken without data or over a pending answer");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped or changed before acceptance");
   a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated after acceptance");
   a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
      else $error("read not answered one cycle after it was taken");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed before acceptance");
   a_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == resp_decerr |-> s_axi_rdata == 32'h0)
      else $error("unmapped read returned nonzero data");
   a_irq_single: assert property (measure_interrupt |=> !measure_interrupt)
      else $error("measurement event longer than one cycle");
   a_route_block: assert property (!gate_output_port_pin_oe |-> !gate_output_port_pin)
      else $error("blocked port pin still driven high");
   a_route_follow: assert property (gate_output_port_pin_oe
      && $past(gate_output_port_pin_oe)
      |-> gate_output_port_pin == $past(companion_timer_output))
      else $error("routed port pin does not follow the companion output");

   c_irq: cover property (measure_interrupt);
   c_decerr: cover property (s_axi_rvalid && s_axi_rresp == resp_decerr);
   c_route: cover property (gate_output_port_pin_oe && gate_output_port_pin);
endmodule

bind gated_frequency_counter freq_meas_checker #(.count_width(count_width)) i_chk (.*);

// *** dv/pulse_source.sv ***
// Purpose: model of the measured pulse source
// Assumes: bursts of pulses two cycles high, two low
// Notes:   between bursts the line rests at the hold level
`timescale 1ns/1ps
module pulse_source
(
   // clock
   input  wire logic        aclk,
   // request
   input  wire logic        go,
   input  wire logic        hold,
   input  wire logic [19:0] count,
   // pulse line
   output      logic        pin,
   output      logic        busy
);
   initial
   begin
      pin = 1'b0;
      busy = 1'b0;
      forever
      begin
         @(posedge aclk);
         if (go)
         begin
            busy <= 1'b1;
            repeat (count)
            begin
               pin <= 1'b1;
               repeat (2) @(posedge aclk);
               pin <= 1'b0;
               repeat (2) @(posedge aclk);
            end
            busy <= 1'b0;
         end
         else
            pin <= hold;
      end
   end
endmodule

// *** dv/tb_gated_frequency_counter.sv ***
// Purpose: self-checking bench for the gated frequency counter
// Assumes: counter narrowed to 8 bits so a wrap fits in a short run
// Notes:   handshakes sampled on the falling edge, inputs moved on the rising edge
`timescale 1ns/1ps
module tb_gated_frequency_counter;
   import freq_meas_pkg::*;
   localparam int cw = 8;
   // one prescale step: 2^4 slow ticks, a slow tick every 2 cycles
   localparam int unit = 2 * (1 << fs_exp_base);
   localparam logic [31:0] run_cfg = (32'(src_external) << src_lsb) | 32'(run_start);
   localparam logic [31:0] clr_cfg = run_cfg | (32'h1 << clear_pos);
   localparam logic [31:0] act = 32'h1 << active_pos;
   localparam logic [31:0] ovf = 32'h1 << ovf_pos;
   logic aclk, aresetn = 1'b0, awready, wready, bvalid, arready, rvalid, busy, port_pin, port_oe;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic gate = 1'b0, comp = 1'b0, go = 1'b0, hold = 1'b0, tick = 1'b0, pin, irq;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic [19:0] count = 20'h0;
   int err_count, comparisons, cyc;
   int irq_at[$];

   gated_frequency_counter #(.count_width(cw)) i_dut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .pulse_input_pin(pin), .pulse_input_signal(gate),
      .companion_timer_output(comp), .low_freq_tick(tick),
      .gate_output_port_pin(port_pin), .gate_output_port_pin_oe(port_oe),
      .measure_interrupt(irq)
   );
   pulse_source i_src (.aclk(aclk), .go(go), .hold(hold), .count(count), .pin(pin), .busy(busy));

   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      tick <= ~tick;
      cyc <= cyc + 1;
      if (irq === 1'b1)
         irq_at.push_back(cyc);
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(negedge aclk);
      while (awready !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      @(negedge aclk);
      while (bvalid !== 1'b1) @(negedge aclk);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge aclk);
      while (arready !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      arvalid <= 1'b0;
      @(negedge aclk);
      while (rvalid !== 1'b1) @(negedge aclk);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk(32'(r), 32'(resp_okay));
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, e);
      chk(32'(r), 32'(resp_okay));
   endtask

   // modes change only while stopped, then the run restarts
   task automatic cfg(input logic [31:0] v);
      w(ctrl_first_off, 32'(run_stop));
      w(ctrl_second_off, v);
      w(ctrl_first_off, run_cfg);
   endtask

   task automatic burst(input int n);
      @(posedge aclk);
      count <= 20'(n);
      go <= 1'b1;
      @(negedge aclk);
      while (busy !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      go <= 1'b0;
      @(negedge aclk);
      while (busy !== 1'b0) @(negedge aclk);
   endtask

   task automatic set_gate(input logic v);
      @(posedge aclk);
      gate <= v;
      repeat (3) @(posedge aclk);
   endtask

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rc(ctrl_first_off, 32'(ctrl_first_rst));
      rc(ctrl_second_off, 32'(ctrl_second_rst));
      rc(gate_period_off, 32'(gate_period_rst));
      rc(status_off, 32'h0);
      rc(capture_off, 32'h0);
      // only the low byte is a register
      w(gate_period_off, 32'h1ab);
      rc(gate_period_off, 32'hab);
      wr(8'h14, 32'h5, r);
      chk(32'(r), 32'(resp_decerr));
      rd(8'h14, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(resp_decerr));
   endtask

   task automatic t_ext();
      cfg(32'(gsrc_pin));
      irq_at.delete();
      set_gate(1'b1);
      rc(status_off, act);
      burst(5);
      set_gate(1'b0);
      rc(status_off, 32'h0);
      rc(capture_off, 32'd5);
      chk(32'(irq_at.size()), 32'd1);
      set_gate(1'b1);
      burst(3);
      set_gate(1'b0);
      burst(2);
      rc(capture_off, 32'd8);
      w(ctrl_first_off, clr_cfg);
      rc(capture_off, 32'h0);
   endtask

   task automatic t_levels();
      cfg(32'h1 << edge_pos);
      @(posedge aclk);
      hold <= 1'b1;
      irq_at.delete();
      set_gate(1'b1);
      set_gate(1'b0);
      rc(capture_off, 32'd1);
      chk(32'(irq_at.size()), 32'd2);
      @(posedge aclk);
      hold <= 1'b0;
      cfg(32'h1 << combine_pos);
      w(ctrl_first_off, clr_cfg);
      set_gate(1'b1);
      set_gate(1'b0);
      rc(capture_off, 32'd1);
   endtask

   task automatic t_ovf();
      cfg(32'(gsrc_pin));
      w(ctrl_first_off, clr_cfg);
      set_gate(1'b1);
      burst(1 << cw);
      set_gate(1'b0);
      rc(capture_off, 32'h0);
      rc(status_off, ovf);
      set_gate(1'b1);
      burst(1);
      set_gate(1'b0);
      rc(capture_off, 32'd1);
      rc(status_off, ovf);
      w(ctrl_first_off, clr_cfg);
      rc(status_off, 32'h0);
   endtask

   task automatic t_internal();
      w(ctrl_first_off, 32'(run_stop));
      w(gate_period_off, (32'd13 << low_lsb) | (32'd14 << high_lsb));
      irq_at.delete();
      cfg(32'(gsrc_internal) | (32'h1 << edge_pos) | (32'h1 << divstage_pos));
      repeat (unit + 2) @(posedge aclk);
      rc(status_off, act);
      while (irq_at.size() < 3) @(posedge aclk);
      chk(32'(irq_at[1] - irq_at[0]), 32'((16 - 14) * unit));
      chk(32'(irq_at[2] - irq_at[1]), 32'((16 - 13) * unit));
      w(ctrl_first_off, 32'(run_stop));
   endtask

   task automatic t_route();
      @(posedge aclk);
      comp <= 1'b1;
      w(ctrl_second_off, 32'h0);
      @(negedge aclk);
      chk({30'h0, port_oe, port_pin}, 32'h3);
      w(ctrl_second_off, 32'h1 << route_pos);
      @(negedge aclk);
      chk({30'h0, port_oe, port_pin}, 32'h0);
      w(ctrl_second_off, (32'h1 << route_pos) | 32'(gsrc_companion));
      w(ctrl_first_off, run_cfg);
      rc(status_off, act);
   endtask

   task automatic end_of_test();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // a whole run needs under two thousand cycles
   initial
   begin
      repeat (20000) @(posedge aclk);
      err_count++;
      end_of_test();
   end

   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_ext();
      t_levels();
      t_ovf();
      t_internal();
      t_route();
      end_of_test();
   end
endmodule
